/* File: rtl/ivp_vector_placement.sv */
// Purpose : Interrupt vector table placement with protected change sequence
// Assumes : Core fetches by 12-bit word address; core gives retire strobe
// Notes   : Avalon-MM slave, one word per register, fixed one wait state
// Notes on behaviour
// RULE_01: With select clear, vectors come from the start of flash.
// RULE_02: With select set, vectors come from the start of the boot section.
// RULE_03: The boot start follows the boot-size fuses only.
// RULE_04: Software sets unlock, then within four cycles writes select with unlock clear.
// RULE_05: Unlock clears itself four cycles after being set or when select is written.
// RULE_06: Interrupts are masked from the unlock cycle until the instruction after the select write completes.
// RULE_07: Without a select write the mask lasts four cycles.
// RULE_08: The masking never touches the core's global enable flag.
// RULE_09: Boot vectors plus application lock block interrupts while running in application code.
// RULE_10: Application vectors plus boot lock block interrupts while running in boot code.
// RULE_11: Control holds select at bit 1 and unlock at bit 0, bits 4..2 read zero, reset clears all.
// RULE_12: With the boot-reset fuse programmed, execution starts at the first boot word.
// RULE_13: A relocated vector address is its default offset plus the boot start.
// RULE_14: Window and mask are counted in clock cycles from the unlock write.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module ivp_vector_placement (
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clockEnable,
  // Avalon-MM slave
  input  wire logic  [3:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic  [3:0] byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Core side
  input  wire logic  [4:0] vectorIndex,
  input  wire logic [11:0] fetchAddress,
  input  wire logic        instrRetire,
  input  wire logic        irqRequest,
  input  wire logic        globalEnable,
  output logic      [11:0] vectorAddress,
  output logic      [11:0] resetAddress,
  output logic             irqToCore,
  output logic             irqMasked
);
  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  logic        ackPhase_r;
  logic        access;
  logic        accept;
  logic        wrLow;
  logic [7:0]  wrByte;
  logic [7:0]  control_r;
  logic [7:0]  fuse_r;
  logic [11:0] bootStart;
  logic        unlockSet;
  logic        selectWrite;
  logic        winBusy;
  logic [2:0]  winCount;
  logic        inBoot;
  logic        lockBlock;
  ivp_pkg::ivp_seq_e seq_r;
  ivp_pkg::ivp_seq_e seq_nxt;

  // One wait state: request is held, accepted on the second edge
  assign access      = read | write;
  assign accept      = access & ackPhase_r;
  assign waitrequest = access & ~ackPhase_r;
  assign wrLow       = write & accept & byteenable[0];
  assign wrByte      = writedata[7:0];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ackPhase_r <= 1'b0;
    end else if (clockEnable) begin
      ackPhase_r <= access & ~ackPhase_r;
    end
  end

  // ---------------------------------------------------------------
  // Control register and change sequence
  // ---------------------------------------------------------------
  // Unlock write: unlock bit one, sequence idle or reopening
  assign unlockSet   = wrLow && (address == ivp_pkg::REG_CONTROL_OFFSET)
                       && wrByte[ivp_pkg::UNLOCK_BIT]; // RULE_04
  // Select write counts only inside the open window with unlock written zero
  assign selectWrite = wrLow && (address == ivp_pkg::REG_CONTROL_OFFSET)
                       && !wrByte[ivp_pkg::UNLOCK_BIT]
                       && control_r[ivp_pkg::UNLOCK_BIT]; // RULE_04

  ivp_window_counter u_window (
    .clock  (clock),
    .resetn (resetn),
    .enable (clockEnable),
    .load   (unlockSet),   // RULE_14
    .abort  (selectWrite),
    .count  (winCount),
    .busy   (winBusy)
  );

  // Select only changes through the protected sequence
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_r <= ivp_pkg::CONTROL_RESET; // RULE_11
    end else if (clockEnable) begin
      if (selectWrite) begin
        control_r[ivp_pkg::SELECT_BIT] <= wrByte[ivp_pkg::SELECT_BIT];
        control_r[ivp_pkg::UNLOCK_BIT] <= 1'b0; // RULE_05
      end else if (unlockSet) begin
        control_r[ivp_pkg::UNLOCK_BIT] <= 1'b1;
      end else if (winCount == 3'h1) begin
        control_r[ivp_pkg::UNLOCK_BIT] <= 1'b0; // RULE_05
      end
    end
  end

  // Fuse and lock settings, written by the programming path over the bus
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fuse_r <= ivp_pkg::FUSE_RESET;
    end else if (clockEnable) begin
      if (wrLow && (address == ivp_pkg::REG_FUSE_OFFSET)) begin
        fuse_r <= {3'h0, wrByte[4:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Masking sequence
  // ---------------------------------------------------------------
  // Idle -> open on unlock; open -> tail on select write; tail ends
  // when the instruction after the select write retires
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      ivp_pkg::SEQ_IDLE: begin
        if (unlockSet) begin
          seq_nxt = ivp_pkg::SEQ_OPEN;
        end
      end
      ivp_pkg::SEQ_OPEN: begin
        if (selectWrite) begin
          seq_nxt = ivp_pkg::SEQ_TAIL; // RULE_06
        end else if (unlockSet) begin
          seq_nxt = ivp_pkg::SEQ_OPEN;
        end else if (winCount == 3'h1) begin
          seq_nxt = ivp_pkg::SEQ_IDLE; // RULE_07
        end
      end
      ivp_pkg::SEQ_TAIL: begin
        if (unlockSet) begin
          seq_nxt = ivp_pkg::SEQ_OPEN;
        end else if (instrRetire) begin
          seq_nxt = ivp_pkg::SEQ_IDLE; // RULE_06
        end
      end
      default: begin
        seq_nxt = ivp_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq_r <= ivp_pkg::SEQ_IDLE;
    end else if (clockEnable) begin
      seq_r <= seq_nxt;
    end
  end

  // Mask asserts combinationally in the unlock cycle itself
  assign irqMasked = unlockSet || (seq_r != ivp_pkg::SEQ_IDLE); // RULE_06 RULE_07

  // ---------------------------------------------------------------
  // Vector placement
  // ---------------------------------------------------------------
  // Boot start taken from the size fuses alone
  always_comb begin
    case (fuse_r[ivp_pkg::FUSE_SIZE_LSB +: 2])
      2'b00:   bootStart = ivp_pkg::BOOT_START_2K;   // RULE_03
      2'b01:   bootStart = ivp_pkg::BOOT_START_1K;   // RULE_03
      2'b10:   bootStart = ivp_pkg::BOOT_START_512;  // RULE_03
      default: bootStart = ivp_pkg::BOOT_START_256;  // RULE_03
    endcase
  end

  // Registered vector and reset addresses keep the fetch path glitch free
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vectorAddress <= ivp_pkg::FLASH_START;
    end else if (clockEnable) begin
      if (control_r[ivp_pkg::SELECT_BIT]) begin
        vectorAddress <= bootStart + {7'h00, vectorIndex}; // RULE_02 RULE_13
      end else begin
        vectorAddress <= ivp_pkg::FLASH_START + {7'h00, vectorIndex}; // RULE_01
      end
    end
  end

  // Fuse programmed means zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resetAddress <= ivp_pkg::FLASH_START;
    end else if (clockEnable) begin
      if (!fuse_r[ivp_pkg::FUSE_RESET_BIT]) begin
        resetAddress <= bootStart; // RULE_12
      end else begin
        resetAddress <= ivp_pkg::FLASH_START;
      end
    end
  end

  // ---------------------------------------------------------------
  // Lock-bit blocking and interrupt gate
  // ---------------------------------------------------------------
  assign inBoot    = (fetchAddress >= bootStart);
  assign lockBlock = (control_r[ivp_pkg::SELECT_BIT] && !inBoot
                      && !fuse_r[ivp_pkg::FUSE_APPLOCK_BIT])    // RULE_09
                  || (!control_r[ivp_pkg::SELECT_BIT] && inBoot
                      && !fuse_r[ivp_pkg::FUSE_BOOTLOCK_BIT]);  // RULE_10

  // Global enable is only read here, never written back
  assign irqToCore = irqRequest && globalEnable && !irqMasked && !lockBlock; // RULE_08

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (clockEnable) begin
      if (read && !ackPhase_r) begin
        case (address)
          ivp_pkg::REG_CONTROL_OFFSET:
            readdata <= {24'h00_0000, control_r & ivp_pkg::CONTROL_RW_MASK}; // RULE_11
          ivp_pkg::REG_STATUS_OFFSET:
            readdata <= {25'h000_0000, winCount, 1'b0, inBoot, lockBlock, irqMasked};
          ivp_pkg::REG_FUSE_OFFSET:
            readdata <= {24'h00_0000, fuse_r};
          default:
            readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: inc/ivp_pkg.sv */
// Purpose : Shared constants for interrupt vector placement block
// Assumes : Word-addressed program flash, 12-bit word address
// Notes   : Register map, field positions, fuse decode and window length
package ivp_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CONTROL_OFFSET = 4'h0;  // General interrupt control
  localparam logic [3:0] REG_STATUS_OFFSET  = 4'h4;  // Live state of the block
  localparam logic [3:0] REG_FUSE_OFFSET    = 4'h8;  // Fuse and lock settings
  localparam logic [7:0] CONTROL_RESET      = 8'h00;

  // Control register fields
  localparam int SELECT_BIT = 1;
  localparam int UNLOCK_BIT = 0;
  localparam logic [7:0] CONTROL_RW_MASK = 8'h03;

  // Status register fields
  localparam int STAT_MASKED_BIT   = 0;
  localparam int STAT_BLOCKED_BIT  = 1;
  localparam int STAT_IN_BOOT_BIT  = 2;
  localparam int STAT_COUNT_LSB    = 4;

  // Fuse register fields
  localparam int FUSE_SIZE_LSB     = 0;
  localparam int FUSE_RESET_BIT    = 2;
  localparam int FUSE_APPLOCK_BIT  = 3;
  localparam int FUSE_BOOTLOCK_BIT = 4;
  localparam logic [7:0] FUSE_RESET = 8'h00;  // All fuses programmed (zero)

  // ---------------------------------------------------------------
  // Flash layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] BOOT_START_2K   = 12'h0C00;  // Size fuses 00
  localparam logic [11:0] BOOT_START_1K   = 12'h0E00;  // Size fuses 01
  localparam logic [11:0] BOOT_START_512  = 12'h0F00;  // Size fuses 10
  localparam logic [11:0] BOOT_START_256  = 12'h0F80;  // Size fuses 11
  localparam logic [11:0] FLASH_START     = 12'h0000;

  // ---------------------------------------------------------------
  // Change window
  // ---------------------------------------------------------------
  localparam logic [2:0] WINDOW_CYCLES = 3'h4;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_OPEN  = 3'b010,
    SEQ_TAIL  = 3'b100
  } ivp_seq_e;
endpackage

/* File: rtl/ivp_window_counter.sv */
// Purpose : Down counter for the protected change window
// Assumes : Load and tick are synchronous to clock
// Notes   : Reports busy while nonzero
`timescale 1ns/1ps
`default_nettype none
module ivp_window_counter (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       enable,
  // Control
  input  wire logic       load,
  input  wire logic       abort,
  // State
  output logic      [2:0] count,
  output logic            busy
);
  // Load wins over abort so a fresh unlock always opens a full window
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= 3'h0;
    end else if (enable) begin
      if (load) begin
        count <= ivp_pkg::WINDOW_CYCLES;
      end else if (abort) begin
        count <= 3'h0;
      end else if (count != 3'h0) begin
        count <= count - 3'h1;
      end
    end
  end

  assign busy = (count != 3'h0);
endmodule
`default_nettype wire

/* File: sim/ivp_vector_placement_monitor.sv */
// Purpose : Port checker for the vector placement block
// Assumes : clockEnable stays high
// Notes   : Bound below to every instance
`timescale 1ns/1ps
`default_nettype none
module ivp_vector_placement_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Register bus
  input wire logic  [3:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic  [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Core side
  input wire logic  [4:0] vectorIndex,
  input wire logic        irqRequest,
  input wire logic        globalEnable,
  input wire logic [11:0] vectorAddress,
  input wire logic [11:0] resetAddress,
  input wire logic        irqToCore,
  input wire logic        irqMasked
);
  // ------------------------------------------
  // Properties
  // ------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Accepted control write carrying the unlock bit
  sequence unlockAcc;
    write && !waitrequest && address == ivp_pkg::REG_CONTROL_OFFSET
      && byteenable[0] && writedata[0];
  endsequence
  // No write at all through the window, so the mask must lapse
  sequence quietFour;
    (!write)[*4];
  endsequence
  chk_unlock_mask: assert property (unlockAcc |-> irqMasked)
    else $error("interrupts not masked in unlock cycle");
  chk_mask_hold: assert property (unlockAcc |=> irqMasked[*4])
    else $error("mask dropped inside the window");
  chk_mask_drop: assert property (unlockAcc ##1 quietFour |=> !irqMasked)
    else $error("mask outlived the window");
  chk_irq_gate: assert property (irqToCore |-> irqRequest && globalEnable && !irqMasked)
    else $error("interrupt passed while gated");
  chk_vec_offset: assert property (1'b1 |=> vectorAddress[6:0] == {2'b00, $past(vectorIndex)})
    else $error("vector offset lost");
  chk_boot_base: assert property (resetAddress inside {12'h000, 12'hc00, 12'he00, 12'hf00, 12'hf80})
    else $error("reset address off the fuse table");
  chk_ctrl_zero: assert property (read && !waitrequest && address == 4'h0 |-> readdata[7:2] == 6'h00)
    else $error("reserved control bits read nonzero");
  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("more than one wait state");
endmodule
bind ivp_vector_placement ivp_vector_placement_monitor chk_u (
  .clock, .resetn, .address, .read, .write, .writedata, .byteenable, .readdata,
  .waitrequest, .vectorIndex, .irqRequest, .globalEnable, .vectorAddress,
  .resetAddress, .irqToCore, .irqMasked
);
`default_nettype wire

/* File: sim/tb_ivp_vector_placement.sv */
// Purpose : Self-checking bench for the vector placement block
// Assumes : One wait state per access, clockEnable held high
// Notes   : Fixed seed; fuse sizes, indexes and fetch addresses are random
`timescale 1ns/1ps
`default_nettype none
module tb_ivp_vector_placement;
  // ------------------------------------------
  // Signals and bench state
  // ------------------------------------------
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic  [3:0] address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic  [3:0] byteenable = 4'hf;
  logic  [4:0] vectorIndex = 5'h00;
  logic [11:0] fetchAddress = 12'h000;
  logic        instrRetire = 1'b0;
  logic        globalEnable = 1'b1;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [11:0] vectorAddress;
  logic [11:0] resetAddress;
  logic        irqToCore;
  logic        irqMasked;
  logic [31:0] rd;
  logic  [1:0] size;
  logic        sel = 1'b0;
  logic        ok;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          gaps [4] = '{0, 1, 2, 6};
  ivp_vector_placement dut_u (
    .clock, .resetn, .clockEnable(1'b1), .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .vectorIndex, .fetchAddress,
    .instrRetire, .irqRequest(1'b1), .globalEnable, .vectorAddress,
    .resetAddress, .irqToCore, .irqMasked
  );
  // Clock at 50 MHz
  always #10 clock = ~clock;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One access held until waitrequest is sampled low at a rising edge; data is taken
  // at that edge, then the bus is released and one edge passes so that
  // back-to-back calls never drive a strobe twice in one time step
  task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] d);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h00_0000, d};
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  // Bus already released by the access task; let n edges pass
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Unlock, wait gap cycles, write the select; late writes must be ignored
  task automatic move(input int gap, input logic v);
    bus(ivp_pkg::REG_CONTROL_OFFSET, 1'b1, 8'h01);
    if (gap > 0) idle(gap);
    bus(ivp_pkg::REG_CONTROL_OFFSET, 1'b1, {6'h00, v, 1'b0});
    idle(2);
  endtask
  // One retired instruction closes the tail of a change
  task automatic retire;
    instrRetire <= 1'b1;
    @(posedge clock);
    instrRetire <= 1'b0;
    @(posedge clock);
  endtask
  // Boot section start for each size code
  function automatic logic [11:0] boot_start(input logic [1:0] s);
    case (s)
      2'b00: return ivp_pkg::BOOT_START_2K;
      2'b01: return ivp_pkg::BOOT_START_1K;
      2'b10: return ivp_pkg::BOOT_START_512;
      default: return ivp_pkg::BOOT_START_256;
    endcase
  endfunction
  // Move the core to pc and compare the gated request; two edges cover a registered decode
  task automatic probe(input logic [11:0] pc, input logic ge, input logic exp);
    fetchAddress <= pc;
    globalEnable <= ge;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(32'(irqToCore), 32'(exp));
    @(posedge clock);
  endtask
  // Main sequence
  initial begin
    void'($urandom(17885));
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    bus(ivp_pkg::REG_CONTROL_OFFSET, 1'b0, 8'h00);
    check(rd, 32'(ivp_pkg::CONTROL_RESET));
    check(32'(resetAddress), 32'(ivp_pkg::BOOT_START_2K));
    byteenable <= 4'h0;
    bus(ivp_pkg::REG_CONTROL_OFFSET, 1'b1, 8'h03);
    byteenable <= 4'hf;
    bus(ivp_pkg::REG_CONTROL_OFFSET, 1'b1, 8'h02);
    bus(4'hc, 1'b0, 8'h00);
    check(rd, 32'h0000_0000);
    bus(ivp_pkg::REG_CONTROL_OFFSET, 1'b0, 8'h00);
    check(rd, 32'h0000_0000);
    idle(1);
    $display("test reset_and_refusals done");
    for (int f = 0; f < 8; f++) begin
      size = 2'($urandom % 4);
      bus(ivp_pkg::REG_FUSE_OFFSET, 1'b1, {3'h0, 2'h3, f[2], size});
      vectorIndex <= 5'($urandom % 17);
      idle(2);
      @(negedge clock);
      check(32'(resetAddress), 32'(f[2] ? 12'h000 : boot_start(size)));
      check(32'(vectorAddress), 32'((sel ? boot_start(size) : 12'h000) + 12'(vectorIndex)));
      @(posedge clock);
      ok = gaps[f % 4] < 2;
      move(gaps[f % 4], !sel);
      @(negedge clock);
      check(32'(irqMasked), 32'(ok));
      check(32'(irqToCore), 32'(!ok));
      @(posedge clock);
      retire();
      @(negedge clock);
      check(32'(irqMasked), 32'h0000_0000);
      @(posedge clock);
      if (ok) sel = !sel;
      bus(ivp_pkg::REG_CONTROL_OFFSET, 1'b0, 8'h00);
      check(rd, 32'({sel, 1'b0}));
      idle(1);
    end
    $display("test select_changes done");
    bus(ivp_pkg::REG_FUSE_OFFSET, 1'b1, 8'h08);
    idle(1);
    probe(12'hc00 + 12'($urandom % 1024), 1'b1, 1'b0);
    probe(12'($urandom % 3072), 1'b1, 1'b1);
    probe(12'($urandom % 3072), 1'b0, 1'b0);
    move(0, 1'b1);
    retire();
    bus(ivp_pkg::REG_FUSE_OFFSET, 1'b1, 8'h10);
    idle(1);
    probe(12'($urandom % 3072), 1'b1, 1'b0);
    probe(12'hc00 + 12'($urandom % 1024), 1'b1, 1'b1);
    $display("test lock_gating done");
    stop_test();
  end
  // Watchdog: the run needs well under 2000 cycles
  initial begin
    #100_000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
